// ==== src/scb_pkg.sv ====
// package for the synthesizer control register bank
// assumes a 24-bit serial frame (rw, 7-bit address, 16-bit data), msb first
package scb_pkg;

  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS  = 7;
  localparam int unsigned DATA_BITS  = 16;
  localparam int unsigned NUM_REGS   = 115;

  // register offsets
  localparam logic [6:0] CORE_CONTROL_OFS       = 7'h00;
  localparam logic [6:0] STATUS_PIN_CONTROL_OFS = 7'h01;
  localparam logic [6:0] READBACK_LOCK_OFS      = 7'h6e;
  localparam logic [6:0] READBACK_CAP_OFS       = 7'h6f;
  localparam logic [6:0] READBACK_BIAS_OFS      = 7'h70;

  // reset values of the two control registers
  localparam logic [15:0] CORE_CONTROL_RST       = 16'h200c;
  localparam logic [15:0] STATUS_PIN_CONTROL_RST = 16'h080c;

  // core_control field positions
  localparam int unsigned PHASE_SYNC_BIT   = 14;
  localparam int unsigned MUTE_BIT         = 9;
  localparam int unsigned CAL_RANGE_HI     = 8;
  localparam int unsigned CAL_RANGE_LO     = 7;
  localparam int unsigned CAL_TRIGGER_BIT  = 3;
  localparam int unsigned PIN_SELECT_BIT   = 2;
  localparam int unsigned SOFT_RESET_BIT   = 1;
  localparam int unsigned POWER_OFF_BIT    = 0;

  // status_pin_control field positions
  localparam int unsigned PIN_DRIVE_BIT    = 3;
  localparam int unsigned CAL_CLK_DIV_HI   = 2;

  // power-on table of the 115 registers; unlisted ones come up zero
  function automatic logic [15:0] scb_reset_value(input int unsigned idx);
    case (idx)
      32'd0:   return CORE_CONTROL_RST;
      32'd1:   return STATUS_PIN_CONTROL_RST;
      32'd48:  return 16'h03e0;
      32'd49:  return 16'h4180;
      32'd50:  return 16'h0080;
      32'd51:  return 16'h0080;
      32'd52:  return 16'h0420;
      32'd58:  return 16'h8001;
      32'd59:  return 16'h0001;
      32'd60:  return 16'h03e8;
      32'd69:  return 16'h0000;
      32'd70:  return 16'hc350;
      32'd71:  return 16'h0080;
      32'd72:  return 16'h0001;
      32'd73:  return 16'h003f;
      32'd74:  return 16'h0000;
      32'd75:  return 16'h0800;
      32'd105: return 16'h0440;
      32'd106: return 16'h0007;
      default: return 16'h0000;
    endcase
  endfunction : scb_reset_value

  // one completed frame handed from the link domain to the core domain
  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [15:0] data;
  } scb_frame_s;

  // outward control levels of the device
  typedef struct packed {
    logic       phase_sync_enable;
    logic       rf_mute;
    logic       power_off;
    logic       in_reset;
    logic [1:0] cal_detector_range;
  } scb_ctrl_s;

endpackage : scb_pkg

// ==== src/scb_top.sv ====
// synthesizer control register bank: serial link slave and 115 x 16-bit registers
// assumes the host drives sclk/cs_n/sdi; sclk may stop outside frames
//
// Contract
// - writing core_control with calibration bit one starts a calibration
// - phase-sync bit routes divider; its rise emits a sync pulse
// - mute bit one silences both rf outputs during calibration
// - status-pin select: readback data at zero, lock detect at one
// - soft-reset bit one holds all registers except core_control, and the state, in reset
// - power-down bit one powers down, zero normal
// - power-on loads 0x200c and 0x80c into the two control registers
// - 24-bit frame, msb first, sampled on rising sclk, committed at cs rise
// - status-pin drive bit zero tri-states the pin, one drives
`timescale 1ns/100ps
`default_nettype none
module scb_top
  import scb_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = 64
)(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_sdi,
  input  wire logic             i_lock_detect,
  output logic                  o_status_pin,
  output logic                  o_status_pin_oe,
  output logic                  o_cal_busy,
  output logic                  o_sync_pulse,
  output scb_pkg::scb_ctrl_s    o_ctrl
);
  import scb_pkg::*;

  // link domain: shift register on rising sclk while selected
  logic [FRAME_BITS-1:0] shift_r;
  logic [4:0]            bitcnt_r;
  logic [4:0]            bitcnt_nxt;
  logic                  rd_hit_r;
  logic [15:0]           rd_word_r;
  logic [4:0]            rd_idx_r;
  logic [15:0]           rd_data_c;
  logic [6:0]            rd_addr_c;

  assign bitcnt_nxt = (bitcnt_r == 5'd31) ? bitcnt_r : bitcnt_r + 5'd1;

  // at the 8th rising edge the last address bit is still on the data pin, not yet in the shifter
  assign rd_addr_c = {shift_r[5:0], i_sdi};

  // bit counter and shifter; cs high clears the count without needing an sclk edge
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      bitcnt_r <= 5'd0;
    end
    else
    begin
      bitcnt_r <= bitcnt_nxt;
    end
  end

  always_ff @(posedge i_sclk)
  begin
    if (!i_cs_n)
    begin
      shift_r <= {shift_r[FRAME_BITS-2:0], i_sdi};
    end
  end

  // readback: after rw and address (8 bits) latch the addressed word from the core copy
  // the word is taken straight from core registers; it is quasi-static during a read frame
  always_ff @(posedge i_sclk)
  begin
    if (!i_cs_n && bitcnt_r == 5'd7)
    begin
      rd_hit_r  <= shift_r[6];
      rd_word_r <= rd_data_c;
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      rd_idx_r <= 5'd0;
    end
    else if (bitcnt_r >= 5'd8 && rd_idx_r != 5'd16)
    begin
      rd_idx_r <= rd_idx_r + 5'd1;
    end
  end

  // frame complete when cs rises: toggle event carries a held frame into the core domain
  scb_frame_s frame_r;
  logic       frame_tgl_r;
  logic       frame_ok;
  assign frame_ok = (bitcnt_r == 5'd24);

  always_ff @(posedge i_cs_n)
  begin
    if (frame_ok)
    begin
      frame_r <= scb_frame_s'(shift_r);
    end
  end

  // the link has no reset of its own; the core reset clears the toggle so no stale frame replays
  always_ff @(posedge i_cs_n or posedge i_rst)
  begin
    if (i_rst)
    begin
      frame_tgl_r <= 1'b0;
    end
    else if (frame_ok)
    begin
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  // core domain: two-flop sync of the frame toggle, then edge detect on the second stage
  logic [2:0] tgl_sync_r;
  logic       frame_evt;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tgl_sync_r <= 3'b000;
    end
    else
    begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
    end
  end
  assign frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];

  // lock detect pin synchroniser
  logic [1:0] lock_sync_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      lock_sync_r <= 2'b00;
    end
    else
    begin
      lock_sync_r <= {lock_sync_r[0], i_lock_detect};
    end
  end

  // register file; frame_r is stable for many core cycles after the toggle is seen
  logic [15:0] regs_r [NUM_REGS];
  logic        wr_evt;
  logic        wr_core;
  logic        soft_rst;
  logic [15:0] rb_lock_c;

  assign wr_evt   = frame_evt && !frame_r.rd && (frame_r.addr < 7'(NUM_REGS));
  assign wr_core  = wr_evt && (frame_r.addr == CORE_CONTROL_OFS);
  assign soft_rst = regs_r[0][SOFT_RESET_BIT];

  // per-register storage; a soft reset reloads every word except core_control, which holds the reset bit
  // and outranks writes, so only core_control writes land while the bank is held in reset
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    localparam logic [15:0] RST_VAL = scb_reset_value(g);
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        regs_r[g] <= RST_VAL;
      end
      else if (soft_rst && g != 0)
      begin
        regs_r[g] <= RST_VAL;
      end
      else if (wr_evt && frame_r.addr == 7'(g) && !(g >= 110 && g <= 112))
      begin
        regs_r[g] <= frame_r.data;
      end
    end
  end

  // read mux; only the lock readback word shows live state, unmapped addresses read zero
  assign rb_lock_c = {5'h00, lock_sync_r[1], 1'b0, 9'h000};
  always_comb
  begin
    rd_data_c = 16'h0000;
    if (rd_addr_c == READBACK_LOCK_OFS)
    begin
      rd_data_c = rb_lock_c;
    end
    else if (rd_addr_c < 7'(NUM_REGS))
    begin
      rd_data_c = regs_r[rd_addr_c];
    end
  end

  // calibration engine: starts only on a core_control write with the trigger bit set
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} scb_cal_e;
  scb_cal_e    cal_state_r;
  logic [15:0] cal_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst || regs_r[0][POWER_OFF_BIT])
    begin
      cal_state_r <= CAL_IDLE;
      cal_cnt_r   <= 16'h0000;
    end
    else
    begin
      case (cal_state_r)
        CAL_IDLE:
        begin
          if (wr_core && frame_r.data[CAL_TRIGGER_BIT] && !frame_r.data[SOFT_RESET_BIT])
          begin
            cal_state_r <= CAL_RUN;
            cal_cnt_r   <= 16'(CAL_CYCLES);
          end
        end
        CAL_RUN:
        begin
          cal_cnt_r <= cal_cnt_r - 16'h0001;
          if (cal_cnt_r == 16'h0001)
          begin
            cal_state_r <= CAL_IDLE;
          end
        end
        default: cal_state_r <= CAL_IDLE;
      endcase
    end
  end

  // phase-sync rise produces a one-cycle sync pulse
  logic sync_prev_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync_prev_r  <= 1'b0;
      o_sync_pulse <= 1'b0;
    end
    else
    begin
      sync_prev_r  <= regs_r[0][PHASE_SYNC_BIT];
      o_sync_pulse <= regs_r[0][PHASE_SYNC_BIT] && !sync_prev_r && !soft_rst;
    end
  end

  // outward control levels, all registered
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ctrl     <= '0;
      o_cal_busy <= 1'b0;
    end
    else
    begin
      o_ctrl.phase_sync_enable  <= regs_r[0][PHASE_SYNC_BIT];
      o_ctrl.rf_mute            <= regs_r[0][MUTE_BIT] && (cal_state_r == CAL_RUN);
      o_ctrl.power_off          <= regs_r[0][POWER_OFF_BIT];
      o_ctrl.in_reset           <= soft_rst;
      o_ctrl.cal_detector_range <= regs_r[0][CAL_RANGE_HI:CAL_RANGE_LO];
      o_cal_busy                <= (cal_state_r == CAL_RUN);
    end
  end

  // status pin in the link domain: readback bit during a read frame with pin select zero, lock detect otherwise, low while cs is high
  // control bits come from the core domain but only change between frames
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      o_status_pin <= 1'b0;
    end
    else if (!regs_r[0][PIN_SELECT_BIT] && rd_hit_r && bitcnt_r >= 5'd8)
    begin
      o_status_pin <= rd_word_r[15 - 4'(rd_idx_r)];
    end
    else
    begin
      o_status_pin <= lock_sync_r[1];
    end
  end

  // pin drive enable is a plain level from status_pin_control
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_status_pin_oe <= 1'b1;
    end
    else
    begin
      o_status_pin_oe <= regs_r[1][PIN_DRIVE_BIT];
    end
  end

endmodule : scb_top
`default_nettype wire

// ==== verif/scb_top_assertions.sv ====
// checker of port timing for the control register bank
// assumes a bind into scb_top; cs_n is sampled on the core clock
`timescale 1ns/100ps
`default_nettype none
module scb_top_assertions
  import scb_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = 64
)(
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_cs_n,
  input wire logic               o_status_pin,
  input wire logic               o_status_pin_oe,
  input wire logic               o_cal_busy,
  input wire logic               o_sync_pulse,
  input wire scb_pkg::scb_ctrl_s o_ctrl
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic        cs_q_r;
  logic [7:0]  since_r;
  logic [15:0] busy_r;
  // cycles since the last frame end, saturating so old frames never excuse a change
  always_ff @(posedge i_clk)
  begin
    cs_q_r <= i_cs_n;
    if (i_rst)
      since_r <= 8'hff;
    else if (i_cs_n && !cs_q_r)
      since_r <= 8'h00;
    else if (since_r != 8'hff)
      since_r <= since_r + 8'h01;
  end
  // length of the current calibration run
  always_ff @(posedge i_clk)
  begin
    busy_r <= (o_cal_busy && !i_rst) ? busy_r + 16'h0001 : 16'h0000;
  end
  sequence s_cal_run;
    o_cal_busy [*8];
  endsequence
  property p_rst_idle;
    $past(i_rst) |-> o_ctrl == '0 && o_status_pin_oe && !o_cal_busy && !o_sync_pulse;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("idle levels wrong after reset");
  property p_cal_start;
    $rose(o_cal_busy) |-> since_r >= 8'd1 && since_r <= 8'd12;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration without a frame");
  property p_cal_hold;
    $rose(o_cal_busy) |-> s_cal_run;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration cut short");
  property p_cal_len;
    $fell(o_cal_busy) && !o_ctrl.in_reset |-> busy_r == CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  property p_sync_once;
    o_sync_pulse |=> !o_sync_pulse;
  endproperty
  a_sync_once: assert property (p_sync_once) else $error("sync pulse too long");
  property p_sync_cause;
    $rose(o_ctrl.phase_sync_enable) |-> (o_sync_pulse || $past(o_sync_pulse)) or ##1 o_sync_pulse;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("no sync pulse on enable");
  property p_mute;
    o_ctrl.rf_mute |-> o_cal_busy || $past(o_cal_busy);
  endproperty
  a_mute: assert property (p_mute) else $error("mute outside calibration");
  property p_soft_rst;
    o_ctrl.in_reset [*2] |-> !o_cal_busy;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("calibration runs in reset");
  property p_ctrl_cause;
    $changed({o_ctrl.power_off, o_ctrl.in_reset, o_ctrl.phase_sync_enable, o_ctrl.cal_detector_range})
      |-> $past(i_rst) || (since_r >= 8'd1 && since_r <= 8'd12);
  endproperty
  a_ctrl_cause: assert property (p_ctrl_cause) else $error("control changed without a frame");
  property p_oe_cause;
    $changed(o_status_pin_oe) |-> $past(i_rst) || (since_r >= 8'd1 && since_r <= 8'd12);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin drive changed without a frame");
  property p_pin_idle;
    i_cs_n [*3] |-> !o_status_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("status pin busy outside frame");
endmodule : scb_top_assertions
bind scb_top scb_top_assertions #(.CAL_CYCLES(CAL_CYCLES)) scb_top_assertions_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_status_pin(o_status_pin),
  .o_status_pin_oe(o_status_pin_oe), .o_cal_busy(o_cal_busy), .o_sync_pulse(o_sync_pulse),
  .o_ctrl(o_ctrl));
`default_nettype wire

// ==== verif/scb_host_model.sv ====
// host model: drives 24-bit frames on the serial link
// assumes one caller at a time; link clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module scb_host_model (
  input  wire logic  i_status_pin,
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic       o_sdi,
  output logic       o_rd_valid,
  output logic [15:0] o_rd_data
);
  // idle link levels
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_data = 16'h0000;
  end
  // one frame of 80 ns bits; read bits taken just before each rising edge
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] data);
    logic [23:0] frame;
    frame = {rd, addr, data};
    #7;
    o_cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      o_sdi <= frame[i];
      #40;
      if (i < 16)
        o_rd_data[i] <= i_status_pin;
      o_sclk <= 1'b1;
      #40;
      o_sclk <= 1'b0;
    end
    #40;
    o_cs_n <= 1'b1;
    o_sdi <= ~frame[0];
    o_rd_valid <= rd;
    #200;
    o_rd_valid <= 1'b0;
  endtask : xfer
endmodule : scb_host_model
`default_nettype wire

// ==== verif/synth_control_register_bank_tb_top.sv ====
// testbench of the control register bank with the host model on the link
// assumes a 50 MHz core clock; reads are queued and matched on completion
`timescale 1ns/100ps
`default_nettype none
module synth_control_register_bank_tb_top
  import scb_pkg::*;
;
  localparam int unsigned CAL_N = 16;
  localparam logic [6:0] RA [7] = '{7'h01, 7'h30, 7'h3a, 7'h46, 7'h4b, 7'h69, 7'h72};
  localparam logic [15:0] RV [7] = '{16'h080c, 16'h03e0, 16'h8001, 16'hc350, 16'h0800, 16'h0440, 16'h0000};
  logic        i_clk = 1'b0;
  logic        i_rst;
  logic        lock_r = 1'b0;
  logic        hold_r = 1'b0;
  logic [31:0] lfsr_r = 32'hd34b381c;
  wire logic   sclk, cs_n, sdi, pin, oe, busy, spulse, rd_valid, pin_w;
  wire logic [15:0] rd_data;
  wire scb_ctrl_s ctrl;
  logic [15:0] exp_q [$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          busy_n = 0;
  int          sync_n = 0;
  scb_top #(.CAL_CYCLES(CAL_N)) scb_top_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .i_lock_detect(lock_r),
    .o_status_pin(pin), .o_status_pin_oe(oe), .o_cal_busy(busy), .o_sync_pulse(spulse), .o_ctrl(ctrl));
  scb_host_model scb_host_model_inst (
    .i_status_pin(pin_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  // a released pin has no pull, so it shows a toggling pattern
  assign pin_w = oe ? pin : i_clk;
  // core clock
  always #10 i_clk = ~i_clk;
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step
  task automatic finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask : chk_bit
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    scb_host_model_inst.xfer(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    scb_host_model_inst.xfer(1'b1, a, 16'h0000);
  endtask : rd
  // random lock level, event counts and the hang limit
  always @(posedge i_clk)
  begin
    lfsr_r <= step(lfsr_r);
    lock_r <= hold_r | lfsr_r[0];
    busy_n <= busy_n + int'(busy === 1'b1);
    sync_n <= sync_n + int'(spulse === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  // oldest noted word against each finished read
  always @(posedge rd_valid)
    chk_word(rd_data, exp_q.pop_front());
  // main sequence
  initial
  begin
    logic [15:0] d;
    int n;
    i_rst <= 1'b1; // a real rising edge at time zero, so the link toggle is cleared
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk_bit(oe, 1'b1);
    wr(7'h00, 16'h2010);
    chk_bit(busy, 1'b0);
    rd(7'h00, 16'h2010);
    for (int i = 0; i < 7; i++)
      rd(RA[i], RV[i]);
    wr(7'h6f, lfsr_r[15:0]);
    rd(7'h6f, 16'h0000);
    rd(7'h75, 16'h0000);
    repeat (4)
    begin
      d = lfsr_r[31:16];
      n = 2 + int'(lfsr_r[5:0]);
      wr(7'(n), d);
      rd(7'(n), d);
    end
    wr(7'h01, 16'h0804);
    chk_bit(oe, 1'b0);
    wr(7'h01, 16'h080c);
    chk_bit(oe, 1'b1);
    n = sync_n;
    wr(7'h00, 16'h6010);
    wr(7'h00, 16'h6010);
    chk_word(16'(sync_n - n), 16'h0001);
    chk_bit(ctrl.phase_sync_enable, 1'b1);
    n = busy_n;
    wr(7'h00, 16'h2398);
    chk_bit(ctrl.rf_mute, 1'b1);
    chk_word({14'h0, ctrl.cal_detector_range}, 16'h0003);
    repeat (CAL_N + 10) @(posedge i_clk);
    chk_word(16'(busy_n - n), 16'(CAL_N));
    chk_bit(ctrl.rf_mute, 1'b0);
    wr(7'h00, 16'h2011);
    chk_bit(ctrl.power_off, 1'b1);
    wr(7'h00, 16'h2010);
    chk_bit(ctrl.power_off, 1'b0);
    wr(7'h30, ~16'h03e0);
    wr(7'h00, 16'h2012);
    chk_bit(ctrl.in_reset, 1'b1);
    wr(7'h00, 16'h2010);
    chk_bit(ctrl.in_reset, 1'b0);
    rd(7'h30, 16'h03e0);
    hold_r <= 1'b1;
    rd(7'h6e, 16'h0400);
    wr(7'h00, 16'h2014);
    rd(7'h30, 16'hffff);
    hold_r <= 1'b0;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk_word(16'(ctrl), 16'h0000);
    wr(7'h00, 16'h2010);
    rd(7'h30, 16'h03e0);
    repeat (10) @(posedge i_clk);
    finish_test();
  end
endmodule : synth_control_register_bank_tb_top
`default_nettype wire
